// ===== rtl/usrxb_check.sv
// Frame checker: masks the character and works out frame and parity errors.
// Assumes a frame from the shift register, purely combinational.
`timescale 1ns/100ps
`default_nettype none

module usrxb_check (
    input wire usrxb_pkg::usrxb_frame_t i_frame,
    input wire usrxb_pkg::usrxb_format_t i_format,
    output usrxb_pkg::usrxb_entry_t o_entry
);

    // ****************************************************************
    // Checking
    // ****************************************************************
    logic [usrxb_pkg::CHAR_W-1:0] masked;

    // Build the entry for the buffer
    always_comb begin
        masked = i_frame.bits & usrxb_pkg::usrxb_char_mask(i_format.char_size_select);
        // R18: unused bits zero
        o_entry.data = masked;
        // R11: first stop bit
        // R12: later stops ignored
        o_entry.frame_err = ~i_frame.stop_bit;
        o_entry.overrun = 1'b0;
        // R19: parity only when enabled
        o_entry.parity_err = i_format.parity_enable_bit &
                             ((^masked) ^ i_frame.parity_bit ^ i_format.parity_odd_even_bit);
    end

endmodule
`default_nettype wire

// ===== rtl/usrxb_fifo.sv
// Two-entry receive buffer; slot zero is always the head, so the head is a flop.
// Assumes the caller pushes only when a slot is free after this cycle's pop.
`timescale 1ns/100ps
`default_nettype none

module usrxb_fifo (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_flush,
    input wire logic i_push,
    input wire usrxb_pkg::usrxb_entry_t i_push_entry,
    input wire logic i_pop,
    input wire logic i_clear_parity,
    output usrxb_pkg::usrxb_entry_t o_head,
    output logic o_head_valid,
    output logic o_full
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    usrxb_pkg::usrxb_entry_t mem_reg [usrxb_pkg::FIFO_DEPTH];
    usrxb_pkg::usrxb_entry_t mem_next [usrxb_pkg::FIFO_DEPTH];
    logic [usrxb_pkg::FIFO_DEPTH-1:0] valid_reg;
    logic [usrxb_pkg::FIFO_DEPTH-1:0] valid_next;

    // Pop shifts down, push fills the lowest free slot
    always_comb begin
        mem_next = mem_reg;
        valid_next = valid_reg;
        // R20: empty read ignored
        // R17: read frees a slot
        if (i_pop && valid_reg[0]) begin
            mem_next[0] = mem_reg[1];
            valid_next[0] = valid_reg[1];
            mem_next[1] = '0;
            valid_next[1] = 1'b0;
        end
        if (i_push) begin
            if (!valid_next[0]) begin
                mem_next[0] = i_push_entry;
                valid_next[0] = 1'b1;
            end else begin
                mem_next[1] = i_push_entry;
                valid_next[1] = 1'b1;
            end
        end
        // R16: zero when parity disabled
        if (i_clear_parity) begin
            mem_next[0].parity_err = 1'b0;
            mem_next[1].parity_err = 1'b0;
        end
        // R5: flush on disable
        if (i_flush) begin
            mem_next[0] = '0;
            mem_next[1] = '0;
            valid_next = '0;
        end
    end

    // Register the buffer
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
            valid_reg <= '0;
        end else begin
            mem_reg <= mem_next;
            valid_reg <= valid_next;
        end
    end

    assign o_head = mem_reg[0];
    assign o_head_valid = valid_reg[0];
    assign o_full = valid_reg[1];

endmodule
`default_nettype wire

// ===== rtl/usrxb_pkg.sv
// Shared types, constants and helpers for the receive buffer block.
// Assumes one system clock and an active high asynchronous reset.
package usrxb_pkg;

    // ****************************************************************
    // Widths and sizes
    // ****************************************************************
    localparam int CHAR_W = 9;
    localparam int BYTE_W = 8;
    localparam int CSZ_W = 3;
    localparam int FIFO_DEPTH = 2;
    localparam int PTR_W = 1;

    // ****************************************************************
    // Register bit positions
    // ****************************************************************
    localparam int ST_RX_COMPLETE = 7;
    localparam int ST_FRAME_ERR = 4;
    localparam int ST_OVERRUN = 3;
    localparam int ST_PARITY_ERR = 2;
    localparam int CTL_RX_NINTH = 1;

    // ****************************************************************
    // Character size codes and reset values
    // ****************************************************************
    localparam logic [CSZ_W-1:0] CSZ_5 = 3'h0;
    localparam logic [CSZ_W-1:0] CSZ_6 = 3'h1;
    localparam logic [CSZ_W-1:0] CSZ_7 = 3'h2;
    localparam logic [CSZ_W-1:0] CSZ_8 = 3'h3;
    localparam logic [CSZ_W-1:0] CSZ_9 = 3'h7;
    localparam logic [CHAR_W-1:0] MASK_5 = 9'h01f;
    localparam logic [CHAR_W-1:0] MASK_6 = 9'h03f;
    localparam logic [CHAR_W-1:0] MASK_7 = 9'h07f;
    localparam logic [CHAR_W-1:0] MASK_8 = 9'h0ff;
    localparam logic [CHAR_W-1:0] MASK_9 = 9'h1ff;
    localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    // One buffered character with its status
    typedef struct packed {
        logic [CHAR_W-1:0] data;
        logic frame_err;
        logic overrun;
        logic parity_err;
    } usrxb_entry_t;

    // Raw frame as handed over by the shift register
    typedef struct packed {
        logic [CHAR_W-1:0] bits;
        logic parity_bit;
        logic stop_bit;
    } usrxb_frame_t;

    // Frame format settings
    typedef struct packed {
        logic [CSZ_W-1:0] char_size_select;
        logic parity_enable_bit;
        logic parity_odd_even_bit;
    } usrxb_format_t;

    // Data bits that belong to the configured character size
    function automatic logic [CHAR_W-1:0] usrxb_char_mask(input logic [CSZ_W-1:0] csz);
        logic [CHAR_W-1:0] m;
        m = MASK_8;
        case (csz)
            CSZ_5: m = MASK_5;
            CSZ_6: m = MASK_6;
            CSZ_7: m = MASK_7;
            CSZ_9: m = MASK_9;
            default: m = MASK_8;
        endcase
        return m;
    endfunction

endpackage

// ===== rtl/usrxb_top.sv
// Receive buffer and status flags of a serial port receiver.
// Assumes the bit sampler on the same clock hands over finished frames and
// start-bit events as one-cycle pulses; the host bus decodes reads into a
// data-read strobe and samples the register images below.
//
// How it works
// R1: Software reads the ninth bit from control before the data register.
// R2: Each entry keeps ninth bit and error flags; data read advances them.
// R3: Software reads status before data, since the data read moves the head.
// R4: Receive-complete is one exactly while an unread character is buffered.
// R5: Clearing receiver enable flushes the buffer and drops receive-complete.
// R6: Interrupt requested while enabled, globally enabled and complete is set.
// R7: Handler must read data to clear complete, or interrupt repeats.
// R8: Error flags are readable but no software write can change them.
// R9: Software writes zero to the error flag positions of status.
// R10: Error flags never raise an interrupt request.
// R11: Frame error shows the first stop bit of the head frame, low gives one.
// R12: Only the first stop bit is checked, whatever the stop count setting.
// R13: Overrun when buffer full, a character waits and a start bit arrives.
// R14: Set overrun means frames were lost before the head frame; here the kept frame is marked and the lost frames came after it.
// R15: Overrun clears when a frame moves from shift register into buffer.
// R16: Parity error shows the head frame's check, zero when parity disabled.
// R17: A buffer entry is free again as soon as it is read.
// R18: Unused upper data bits read zero for short characters.
// R19: Parity checked only with the enable bit; other bit picks odd or even.
// R20: A data read on an empty buffer changes nothing.
// R21: The head's ninth bit shows at bit one of the control register.
`timescale 1ns/100ps
`default_nettype none

module usrxb_top (
    input wire logic I_MCLK,
    input wire logic I_RESET,
    input wire logic I_RECEIVER_ENABLE,
    input wire logic [2:0] I_CHAR_SIZE_SELECT,
    input wire logic I_PARITY_ENABLE_BIT,
    input wire logic I_PARITY_ODD_EVEN_BIT,
    input wire logic I_RX_COMPLETE_IRQ_ENABLE,
    input wire logic I_GLOBAL_IRQ_ENABLE,
    input wire logic I_START_DETECT,
    input wire logic I_FRAME_DONE,
    input wire logic [8:0] I_FRAME_BITS,
    input wire logic I_FRAME_PARITY,
    input wire logic I_FRAME_STOP,
    input wire logic I_DATA_READ,
    output logic [7:0] O_SERIAL_DATA_REG,
    output logic [7:0] O_SERIAL_STATUS_REG,
    output logic [7:0] O_SERIAL_CONTROL_RX,
    output logic O_RX_COMPLETE_IRQ
);

    // ****************************************************************
    // Input grouping
    // ****************************************************************
    usrxb_pkg::usrxb_format_t format;
    usrxb_pkg::usrxb_frame_t frame;
    usrxb_pkg::usrxb_entry_t checked;

    // Bundle format and frame for the checker
    always_comb begin
        format.char_size_select = I_CHAR_SIZE_SELECT;
        format.parity_enable_bit = I_PARITY_ENABLE_BIT;
        format.parity_odd_even_bit = I_PARITY_ODD_EVEN_BIT;
        frame.bits = I_FRAME_BITS;
        frame.parity_bit = I_FRAME_PARITY;
        frame.stop_bit = I_FRAME_STOP;
    end

    // ****************************************************************
    // Frame check
    // ****************************************************************
    // Checked with the format in force when the frame ends
    usrxb_check u_check (
        .i_frame(frame),
        .i_format(format),
        .o_entry(checked)
    );

    // ****************************************************************
    // Shift register stage and overrun
    // ****************************************************************
    usrxb_pkg::usrxb_entry_t hold_reg;
    usrxb_pkg::usrxb_entry_t hold_next;
    logic hold_valid_reg;
    logic hold_valid_next;
    logic overrun_reg;
    logic overrun_next;
    usrxb_pkg::usrxb_entry_t head;
    usrxb_pkg::usrxb_entry_t push_entry;
    logic head_valid;
    logic fifo_full;
    logic room;
    logic move;
    logic flush;

    // Disabling the receiver is immediate
    assign flush = ~I_RECEIVER_ENABLE;

    // A slot is free when the buffer is not full or the head leaves now
    assign room = ~fifo_full | (I_DATA_READ & head_valid);
    assign move = hold_valid_reg & room & I_RECEIVER_ENABLE;

    // The waiting character carries the overrun mark into the buffer
    always_comb begin
        push_entry = hold_reg;
        push_entry.overrun = overrun_reg;
    end

    // Next values of the waiting character and the overrun mark
    always_comb begin
        hold_next = hold_reg;
        hold_valid_next = hold_valid_reg & ~move;
        overrun_next = overrun_reg;
        // Capture a finished frame if the stage is or becomes free
        if (I_FRAME_DONE && I_RECEIVER_ENABLE && (!hold_valid_reg || move)) begin
            hold_next = checked;
            hold_valid_next = 1'b1;
        end
        // R15: clear on transfer
        if (move) begin
            overrun_next = 1'b0;
        end
        // R13: full, waiting, new start
        // R14: lost frames marked
        if (I_START_DETECT && I_RECEIVER_ENABLE && fifo_full && hold_valid_reg && !move) begin
            overrun_next = 1'b1;
        end
        // R5: ongoing data dropped
        if (flush) begin
            hold_next = '0;
            hold_valid_next = 1'b0;
            overrun_next = 1'b0;
        end
    end

    // Register the shift register stage
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            hold_reg <= '0;
            hold_valid_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            hold_reg <= hold_next;
            hold_valid_reg <= hold_valid_next;
            overrun_reg <= overrun_next;
        end
    end

    // ****************************************************************
    // Receive buffer
    // ****************************************************************
    // R2: status stored per entry
    // R17: read frees the slot
    usrxb_fifo u_fifo (
        .i_clk(I_MCLK),
        .i_reset(I_RESET),
        .i_flush(flush),
        .i_push(move),
        .i_push_entry(push_entry),
        .i_pop(I_DATA_READ),
        .i_clear_parity(~I_PARITY_ENABLE_BIT),
        .o_head(head),
        .o_head_valid(head_valid),
        .o_full(fifo_full)
    );

    // ****************************************************************
    // Register images
    // ****************************************************************
    // R18: masked data low byte
    assign O_SERIAL_DATA_REG = head.data[usrxb_pkg::BYTE_W-1:0];

    // Status image; error flags come only from the buffer head
    always_comb begin
        O_SERIAL_STATUS_REG = usrxb_pkg::REG_RESET;
        // R4: complete while unread
        O_SERIAL_STATUS_REG[usrxb_pkg::ST_RX_COMPLETE] = head_valid;
        // R8: no write path
        // R11: head frame error
        O_SERIAL_STATUS_REG[usrxb_pkg::ST_FRAME_ERR] = head.frame_err;
        O_SERIAL_STATUS_REG[usrxb_pkg::ST_OVERRUN] = head.overrun;
        // R16: head parity error
        O_SERIAL_STATUS_REG[usrxb_pkg::ST_PARITY_ERR] = head.parity_err;
    end

    // Control image carries the head's ninth bit
    always_comb begin
        O_SERIAL_CONTROL_RX = usrxb_pkg::REG_RESET;
        // R21: ninth bit at one
        O_SERIAL_CONTROL_RX[usrxb_pkg::CTL_RX_NINTH] = head.data[usrxb_pkg::CHAR_W-1];
    end

    // ****************************************************************
    // Receive-complete interrupt
    // ****************************************************************
    logic irq_reg;
    logic irq_next;

    // R6: level while complete set
    // R10: errors not a source
    always_comb begin
        irq_next = I_RX_COMPLETE_IRQ_ENABLE & I_GLOBAL_IRQ_ENABLE & head_valid;
    end

    // Register the request
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign O_RX_COMPLETE_IRQ = irq_reg;

endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the receive buffer flags block.
// Assumes the sender model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Bench top
// ****************************************************************
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b0;
    logic [2:0] csz = usrxb_pkg::CSZ_8;
    logic pen = 1'b0;
    logic podd = 1'b0;
    logic irqen = 1'b0;
    logic gen = 1'b0;
    logic rd = 1'b0;
    logic start, done, par, stop, irq;
    logic [8:0] bits;
    logic [7:0] data, status, ctl;
    int failures = 0;
    int check_count = 0;

    // Clock and the far side
    always #5 clk = ~clk;
    usrxb_sender sender (.i_clk(clk), .o_start(start), .o_done(done), .o_bits(bits), .o_parity(par),
        .o_stop(stop));
    usrxb_top dut (.I_MCLK(clk), .I_RESET(rst), .I_RECEIVER_ENABLE(en), .I_CHAR_SIZE_SELECT(csz),
        .I_PARITY_ENABLE_BIT(pen), .I_PARITY_ODD_EVEN_BIT(podd), .I_RX_COMPLETE_IRQ_ENABLE(irqen),
        .I_GLOBAL_IRQ_ENABLE(gen), .I_START_DETECT(start), .I_FRAME_DONE(done), .I_FRAME_BITS(bits),
        .I_FRAME_PARITY(par), .I_FRAME_STOP(stop), .I_DATA_READ(rd), .O_SERIAL_DATA_REG(data),
        .O_SERIAL_STATUS_REG(status), .O_SERIAL_CONTROL_RX(ctl), .O_RX_COMPLETE_IRQ(irq));

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Byte compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Status image from its flags
    function automatic logic [7:0] st(input logic c, input logic f, input logic o, input logic p);
        logic [7:0] s;
        s = 8'h00;
        s[usrxb_pkg::ST_RX_COMPLETE] = c;
        s[usrxb_pkg::ST_FRAME_ERR] = f;
        s[usrxb_pkg::ST_OVERRUN] = o;
        s[usrxb_pkg::ST_PARITY_ERR] = p;
        return s;
    endfunction

    // status is only read here; the block has no status write path
    task automatic look(input logic [7:0] s, input logic [7:0] c, input logic [7:0] d, input logic i);
        @(negedge clk);
        chk(status, s);
        chk(ctl, c);
        chk(data, d);
        chk({7'h00, irq}, {7'h00, i});
    endtask

    // Host helpers: format, data read pulse, one frame landed
    task automatic cfg(input logic [2:0] c, input logic p, input logic o);
        @(posedge clk);
        csz <= c;
        pen <= p;
        podd <= o;
    endtask
    task automatic pop();
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
    endtask
    task automatic frame(input logic [8:0] b, input logic p, input logic s);
        sender.send(b, p, s);
        repeat (2) @(negedge clk);
    endtask

    // ninth bit, interrupt held and dropped
    task automatic t_nine();
        cfg(usrxb_pkg::CSZ_9, 1'b1, 1'b0);
        frame(9'h1a5, ^9'h1a5, 1'b1);
        look(st(1, 0, 0, 0), 8'h02, 8'ha5, 1'b1);
        @(posedge clk);
        gen <= 1'b0;
        @(negedge clk);
        look(st(1, 0, 0, 0), 8'h02, 8'ha5, 1'b0);
        @(posedge clk);
        gen <= 1'b1;
        pop();
        look(8'h00, 8'h00, 8'h00, 1'b0);
    endtask

    task automatic t_err();
        cfg(usrxb_pkg::CSZ_8, 1'b1, 1'b1);
        frame(9'h1f0, 1'b0, 1'b0);
        frame(9'h03c, 1'b1, 1'b1);
        look(st(1, 1, 0, 1), 8'h00, 8'hf0, 1'b1);
        @(posedge clk);
        pen <= 1'b0;
        @(negedge clk);
        look(st(1, 1, 0, 0), 8'h00, 8'hf0, 1'b1);
        @(posedge clk);
        pen <= 1'b1;
        pop();
        look(st(1, 0, 0, 0), 8'h00, 8'h3c, 1'b1);
        pop();
        look(8'h00, 8'h00, 8'h00, 1'b0);
    endtask

    // every character size, plus an unlisted code that acts as eight bits
    task automatic t_sizes();
        logic [2:0] codes [6] = '{usrxb_pkg::CSZ_5, usrxb_pkg::CSZ_6, usrxb_pkg::CSZ_7,
            usrxb_pkg::CSZ_8, usrxb_pkg::CSZ_9, 3'h4};
        logic [7:0] masks [6] = '{8'h1f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff};
        for (int i = 0; i < 6; i++) begin
            cfg(codes[i], 1'b0, 1'b0);
            frame(9'h1ff, 1'b0, 1'b1);
            look(st(1, 0, 0, 0), (i == 4) ? 8'h02 : 8'h00, masks[i], 1'b1);
            pop();
        end
    endtask

    task automatic t_over();
        cfg(usrxb_pkg::CSZ_8, 1'b0, 1'b0);
        sender.send(9'h011, 1'b0, 1'b1);
        sender.send(9'h022, 1'b0, 1'b1);
        sender.send(9'h033, 1'b0, 1'b1);
        sender.send(9'h044, 1'b0, 1'b1);
        repeat (2) @(negedge clk);
        look(st(1, 0, 0, 0), 8'h00, 8'h11, 1'b1);
        pop();
        look(st(1, 0, 0, 0), 8'h00, 8'h22, 1'b1);
        pop();
        look(st(1, 0, 1, 0), 8'h00, 8'h33, 1'b1);
        pop();
        look(8'h00, 8'h00, 8'h00, 1'b0);
        frame(9'h055, 1'b0, 1'b1);
        look(st(1, 0, 0, 0), 8'h00, 8'h55, 1'b1);
        pop();
    endtask

    // flush by disable, then a read on empty
    task automatic t_flush();
        frame(9'h0aa, 1'b0, 1'b1);
        frame(9'h0bb, 1'b0, 1'b1);
        @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        @(negedge clk);
        look(8'h00, 8'h00, 8'h00, 1'b0);
        pop();
        look(8'h00, 8'h00, 8'h00, 1'b0);
        frame(9'h0cc, 1'b0, 1'b1);
        look(st(1, 0, 0, 0), 8'h00, 8'hcc, 1'b1);
        pop();
    endtask

    // Main sequence after reset
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        en <= 1'b1;
        irqen <= 1'b1;
        gen <= 1'b1;
        look(8'h00, 8'h00, 8'h00, 1'b0);
        t_nine();
        t_err();
        t_sizes();
        t_over();
        t_flush();
        summarize();
    end

    // Hang limit
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        summarize();
    end
endmodule
`default_nettype wire

// ===== sim/usrxb_monitor.sv
// Port checker for the receive buffer flags block, bound to its top module.
// Assumes a single clock domain with an active high reset.
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Checker
// ****************************************************************
module usrxb_monitor (
    input wire logic I_MCLK,
    input wire logic I_RESET,
    input wire logic I_RECEIVER_ENABLE,
    input wire logic [2:0] I_CHAR_SIZE_SELECT,
    input wire logic I_PARITY_ENABLE_BIT,
    input wire logic I_PARITY_ODD_EVEN_BIT,
    input wire logic I_RX_COMPLETE_IRQ_ENABLE,
    input wire logic I_GLOBAL_IRQ_ENABLE,
    input wire logic I_START_DETECT,
    input wire logic I_FRAME_DONE,
    input wire logic [8:0] I_FRAME_BITS,
    input wire logic I_FRAME_PARITY,
    input wire logic I_FRAME_STOP,
    input wire logic I_DATA_READ,
    input wire logic [7:0] O_SERIAL_DATA_REG,
    input wire logic [7:0] O_SERIAL_STATUS_REG,
    input wire logic [7:0] O_SERIAL_CONTROL_RX,
    input wire logic O_RX_COMPLETE_IRQ
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RESET);

    // Status picks and frame slices
    wire logic rxc = O_SERIAL_STATUS_REG[usrxb_pkg::ST_RX_COMPLETE];
    wire logic fe = O_SERIAL_STATUS_REG[usrxb_pkg::ST_FRAME_ERR];
    wire logic pe = O_SERIAL_STATUS_REG[usrxb_pkg::ST_PARITY_ERR];
    wire logic [7:0] bits_lo = I_FRAME_BITS[7:0];
    wire logic bit_hi = I_FRAME_BITS[8];

    // Frame taken with buffer and stage empty, then left to land
    sequence s_take;
        I_FRAME_DONE && I_RECEIVER_ENABLE && !rxc && !$past(I_FRAME_DONE);
    endsequence
    sequence s_land;
        s_take ##1 I_RECEIVER_ENABLE ##1 (I_RECEIVER_ENABLE && !I_DATA_READ);
    endsequence

    a_frame_lands:
    assert property (s_land |=> rxc) else $error("frame did not land");
    a_stop_check:
    assert property (s_land |=> fe == !$past(I_FRAME_STOP, 3)) else $error("frame error wrong");
    a_data_lands:
    assert property (s_land ##0 ($past(I_CHAR_SIZE_SELECT, 2) == usrxb_pkg::CSZ_8)
        |=> O_SERIAL_DATA_REG == $past(bits_lo, 3)) else $error("data wrong");
    a_ninth_lands:
    assert property (s_land ##0 ($past(I_CHAR_SIZE_SELECT, 2) == usrxb_pkg::CSZ_9)
        |=> O_SERIAL_CONTROL_RX == {6'h00, $past(bit_hi, 3), 1'b0}) else $error("ninth bit wrong");
    a_flush_empty:
    assert property (!I_RECEIVER_ENABLE |=> !rxc && O_SERIAL_DATA_REG == 8'h00) else $error("no flush");
    a_parity_off:
    assert property (!I_PARITY_ENABLE_BIT |=> !pe) else $error("parity error while off");
    a_empty_zero:
    assert property (!rxc |-> O_SERIAL_STATUS_REG == 8'h00 && O_SERIAL_DATA_REG == 8'h00
        && O_SERIAL_CONTROL_RX == 8'h00) else $error("empty buffer shows data");
    a_irq_request:
    assert property (I_RX_COMPLETE_IRQ_ENABLE && I_GLOBAL_IRQ_ENABLE && rxc |=> O_RX_COMPLETE_IRQ)
        else $error("interrupt missing");
    a_irq_cause:
    assert property (O_RX_COMPLETE_IRQ |-> $past(rxc) && $past(I_GLOBAL_IRQ_ENABLE))
        else $error("interrupt without data");
endmodule

bind usrxb_top usrxb_monitor u_mon (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
    .I_RECEIVER_ENABLE(I_RECEIVER_ENABLE), .I_CHAR_SIZE_SELECT(I_CHAR_SIZE_SELECT),
    .I_PARITY_ENABLE_BIT(I_PARITY_ENABLE_BIT), .I_PARITY_ODD_EVEN_BIT(I_PARITY_ODD_EVEN_BIT),
    .I_RX_COMPLETE_IRQ_ENABLE(I_RX_COMPLETE_IRQ_ENABLE), .I_GLOBAL_IRQ_ENABLE(I_GLOBAL_IRQ_ENABLE),
    .I_START_DETECT(I_START_DETECT), .I_FRAME_DONE(I_FRAME_DONE), .I_FRAME_BITS(I_FRAME_BITS),
    .I_FRAME_PARITY(I_FRAME_PARITY), .I_FRAME_STOP(I_FRAME_STOP), .I_DATA_READ(I_DATA_READ),
    .O_SERIAL_DATA_REG(O_SERIAL_DATA_REG), .O_SERIAL_STATUS_REG(O_SERIAL_STATUS_REG),
    .O_SERIAL_CONTROL_RX(O_SERIAL_CONTROL_RX), .O_RX_COMPLETE_IRQ(O_RX_COMPLETE_IRQ));
`default_nettype wire

// ===== sim/usrxb_sender.sv
// Remote transmitter model: start events and finished frames for the receiver.
// Assumes the bench calls send from its main process, one frame at a time.
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// Frame sender
// ****************************************************************
module usrxb_sender (
    input wire logic i_clk,
    output logic o_start,
    output logic o_done,
    output logic [8:0] o_bits,
    output logic o_parity,
    output logic o_stop
);
    // Idle values at time zero
    initial begin
        o_start = 1'b0;
        o_done = 1'b0;
        o_bits = 9'h000;
        o_parity = 1'b0;
        o_stop = 1'b1;
    end

    // first stop only
    // One start pulse, then the frame pulse; lines show inverted junk outside it
    task automatic send(input logic [8:0] b, input logic p, input logic s);
        @(posedge i_clk);
        o_start <= 1'b1;
        @(posedge i_clk);
        o_start <= 1'b0;
        @(posedge i_clk);
        o_done <= 1'b1;
        o_bits <= b;
        o_parity <= p;
        o_stop <= s;
        @(posedge i_clk);
        o_done <= 1'b0;
        o_bits <= ~b;
        o_parity <= ~p;
        o_stop <= ~s;
    endtask
endmodule
`default_nettype wire
